// ===== hdl/bit_exec_regs.svh
/*
 * Offsets, field positions, reset values and fixed addresses of the
 * bit test and table load execution block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BIT_EXEC_REGS_SVH
`define BIT_EXEC_REGS_SVH

// Software register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_FLAGS 8'h08
`define OFS_REG_IDX 8'h0C
`define OFS_REG_DATA 8'h10
`define OFS_PROG_IDX 8'h14
`define OFS_PROG_DATA 8'h18

// Control and status fields
`define CTRL_DSS_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT 1
`define STAT_LEN_LSB 4
`define CTRL_RESET 8'h00
`define FLAGS_RESET 8'h00

// Condition code bit positions
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4

// Write-only control registers in register space
`define ADDR_PRESCALER1 8'hF3
`define ADDR_PRESCALER0 8'hF5
`define ADDR_PORT2_MODE 8'hF6
`define ADDR_PORT3_MODE 8'hF7
`define ADDR_PORT01_MODE 8'hF8
`define ADDR_IRQ_PRIORITY 8'hF9

// Internal program memory size and instruction lengths
`define INT_PROG_BYTES 2048
`define LEN_LOAD_IMM_FULL 2'h3
`define LEN_LOAD_IMM_SHORT 2'h2

`endif

// ===== hdl/bit_exec_pkg.sv
/*
 * Types shared by the execution block and its bit unit.
 * Assumes nothing of its surroundings.
 */
package bit_exec_pkg;
	typedef enum logic [3:0] {
		OP_NOP,
		OP_MASK_ZERO_TEST,
		OP_MASK_ONE_TEST,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_INVERT_ALL,
		OP_PROGRAM_MEM_LOAD,
		OP_PROGRAM_MEM_LOAD_INCR,
		OP_EXT_DATA_LOAD,
		OP_EXT_DATA_LOAD_INCR,
		OP_LOAD_IMM
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INT_RD,
		ST_EXT_REQ,
		ST_EXT_REL
	} state_t;
endpackage

// ===== hdl/bitop_if.sv
/*
 * Carrier between the execution block and its bit unit.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface bitop_if;
	bit_exec_pkg::op_t op;
	logic [7:0] dst;
	logic [7:0] mask;
	logic [7:0] flags_in;
	logic [7:0] result;
	logic [7:0] flags_out;
	logic write_back;
	modport core (output op, dst, mask, flags_in, input result, flags_out, write_back);
	modport unit (input op, dst, mask, flags_in, output result, flags_out, write_back);
endinterface

// ===== hdl/bitop_unit.sv
/*
 * Combinational masked test and modify unit.
 * Assumes the caller registers result and flags.
 */
`timescale 1ns/100ps
`include "bit_exec_regs.svh"
module bitop_unit (
	// Operand and result carrier
	bitop_if.unit bi
);
	logic [7:0] res;

	// Operation and flag update
	always_comb begin
		res = 8'h00;
		bi.write_back = 1'b0;
		case (bi.op)
			bit_exec_pkg::OP_MASK_ZERO_TEST: res = bi.dst & bi.mask;
			bit_exec_pkg::OP_MASK_ONE_TEST: res = ~bi.dst & bi.mask;
			bit_exec_pkg::OP_AND: begin
				res = bi.dst & bi.mask;
				bi.write_back = 1'b1;
			end
			bit_exec_pkg::OP_OR: begin
				res = bi.dst | bi.mask;
				bi.write_back = 1'b1;
			end
			bit_exec_pkg::OP_XOR: begin
				res = bi.dst ^ bi.mask;
				bi.write_back = 1'b1;
			end
			bit_exec_pkg::OP_INVERT_ALL: begin
				res = ~bi.dst;
				bi.write_back = 1'b1;
			end
			default: res = 8'h00;
		endcase
		bi.result = res;
		// Only Z, S and V move; tests never write the operand
		bi.flags_out = bi.flags_in;
		bi.flags_out[`FLAG_Z] = (res == 8'h00);
		bi.flags_out[`FLAG_S] = res[7];
		bi.flags_out[`FLAG_V] = 1'b0;
	end
endmodule

// ===== hdl/bit_exec.sv
/*
 * Execution datapath: masked bit test and modify operations, program
 * memory and external data memory loads with auto-increment, and a
 * software register port. Assumes a memory bus partner that answers a
 * held request with an acknowledge level from another clock domain.
 */
`timescale 1ns/100ps
`include "bit_exec_regs.svh"

//////////////////////////////////////////////////////////////////////
// Contract
// - Zero-test ANDs destination with mask, result only sets flags.
// - Both tests leave operands unchanged; only flags are altered.
// - Zero-test sets Z when all selected bits are 0, else clears.
// - Zero-test drives sign from the AND result.
// - Zero-test clears V and leaves other flags untouched.
// - One-test ANDs the inverted destination with the mask.
// - A bit is selected exactly when its mask bit is 1.
// - AND clears unselected bits, OR sets selected, XOR inverts selected.
// - Invert-all complements every bit and takes no mask.
// - Bit ops reach any register except the six write-only ones.
// - Incrementing external load moves a byte then bumps both pointers.
// - Program-memory load reads constant bytes from program memory.
// - External load uses data memory, kept apart when select enabled.
// - Incrementing program load copies table bytes into consecutive registers.
// - Lowest 2K of program memory is internal, with no bus cycle.
// - Load-immediate is three bytes full address, two bytes short.
// - One-test sets Z only when all selected bits are 1; V cleared.
// - Loads take address from a register pair; incr variants bump both.
module bit_exec #(
	parameter int PROG_BYTES = `INT_PROG_BYTES
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Software register port
	input wire logic [7:0] sw_addr_in,
	input wire logic [7:0] sw_wdata_in,
	input wire logic sw_wr_in,
	input wire logic sw_rd_in,
	output logic [7:0] sw_rdata_out,
	// Instruction command
	input wire logic cmd_valid_in,
	input wire logic [3:0] cmd_op_in,
	input wire logic [7:0] cmd_dst_in,
	input wire logic [7:0] cmd_src_in,
	input wire logic [7:0] cmd_pair_in,
	input wire logic cmd_store_in,
	input wire logic cmd_short_in,
	output logic busy_out,
	output logic [7:0] flags_out,
	// External memory bus
	output logic [15:0] mem_addr_out,
	output logic mem_req_out,
	output logic mem_we_out,
	output logic [7:0] mem_wdata_out,
	output logic data_space_select_out,
	input wire logic mem_ack_in,
	input wire logic [7:0] mem_rdata_in
);
	bitop_if bi();
	bit_exec_pkg::state_t state_r;
	logic [7:0] regs_r [0:255];
	logic [7:0] prog_r [0:PROG_BYTES-1];
	logic [7:0] ctrl_r, flags_r, reg_idx_r, status_r;
	logic [15:0] prog_idx_r;
	logic err_r;
	logic [1:0] len_r;
	logic ack_s1_r, ack_s2_r, ack_s3_r, ack_lvl_r;
	logic [7:0] tgt_r, pair_r;
	logic incr_r, store_r, is_ext_r;
	logic [15:0] maddr_r;
	logic [7:0] pdata_r;
	bit_exec_pkg::op_t cmd_op;
	logic accept, bit_go, mem_go, imm_go, wr_only;
	logic xfer_done;
	logic [7:0] xfer_data;
	logic [15:0] pair_addr;

	// Bit unit
	bitop_unit u_bitop (
		.bi(bi)
	);

	// Write-only control registers cannot be read for modification
	function automatic logic is_write_only(input logic [7:0] a);
		return a == `ADDR_PRESCALER0 || a == `ADDR_PRESCALER1 || a == `ADDR_PORT01_MODE ||
			a == `ADDR_PORT2_MODE || a == `ADDR_PORT3_MODE || a == `ADDR_IRQ_PRIORITY;
	endfunction

	// Pair address, forced to an even register
	function automatic logic [15:0] pair_of(input logic [7:0] p, input logic [7:0] hi, input logic [7:0] lo);
		return {hi, lo};
	endfunction

	//////////////////////////////////////////////////////////////////
	// Command decode
	always_comb begin
		cmd_op = bit_exec_pkg::op_t'(cmd_op_in);
		accept = cmd_valid_in && state_r == bit_exec_pkg::ST_IDLE;
		wr_only = is_write_only(cmd_dst_in);
		bit_go = accept && cmd_op >= bit_exec_pkg::OP_MASK_ZERO_TEST &&
			cmd_op <= bit_exec_pkg::OP_INVERT_ALL && !wr_only;
		mem_go = accept && cmd_op >= bit_exec_pkg::OP_PROGRAM_MEM_LOAD &&
			cmd_op <= bit_exec_pkg::OP_EXT_DATA_LOAD_INCR;
		imm_go = accept && cmd_op == bit_exec_pkg::OP_LOAD_IMM;
		pair_addr = pair_of(cmd_pair_in, regs_r[{cmd_pair_in[7:1], 1'b0}],
			regs_r[{cmd_pair_in[7:1], 1'b1}]);
		bi.op = bit_go ? cmd_op : bit_exec_pkg::OP_NOP;
		bi.dst = regs_r[cmd_dst_in];
		bi.mask = cmd_src_in;
		bi.flags_in = flags_r;
	end

	// Completion of a memory transfer
	always_comb begin
		xfer_done = 1'b0;
		xfer_data = pdata_r;
		if (state_r == bit_exec_pkg::ST_INT_RD) begin
			xfer_done = 1'b1;
		end else if (state_r == bit_exec_pkg::ST_EXT_REQ && ack_lvl_r) begin
			xfer_done = 1'b1;
			xfer_data = mem_rdata_in;
		end
	end

	//////////////////////////////////////////////////////////////////
	// Acknowledge synchroniser; level counts when stages two and three agree
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_s3_r <= 1'b0;
			ack_lvl_r <= 1'b0;
		end else begin
			ack_s1_r <= mem_ack_in;
			ack_s2_r <= ack_s1_r;
			ack_s3_r <= ack_s2_r;
			if (ack_s2_r == ack_s3_r) begin
				ack_lvl_r <= ack_s3_r;
			end
		end
	end

	// Transfer sequencer
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= bit_exec_pkg::ST_IDLE;
			busy_out <= 1'b0;
			tgt_r <= 8'h00;
			pair_r <= 8'h00;
			incr_r <= 1'b0;
			store_r <= 1'b0;
			is_ext_r <= 1'b0;
			maddr_r <= 16'h0000;
		end else begin
			case (state_r)
				bit_exec_pkg::ST_IDLE: begin
					if (mem_go) begin
						tgt_r <= cmd_dst_in;
						pair_r <= {cmd_pair_in[7:1], 1'b0};
						incr_r <= cmd_op == bit_exec_pkg::OP_PROGRAM_MEM_LOAD_INCR ||
							cmd_op == bit_exec_pkg::OP_EXT_DATA_LOAD_INCR;
						is_ext_r <= cmd_op >= bit_exec_pkg::OP_EXT_DATA_LOAD;
						store_r <= cmd_store_in && cmd_op >= bit_exec_pkg::OP_EXT_DATA_LOAD;
						maddr_r <= pair_addr;
						busy_out <= 1'b1;
						// Low program space served on chip
						if (cmd_op < bit_exec_pkg::OP_EXT_DATA_LOAD && pair_addr < 16'(PROG_BYTES)) begin
							state_r <= bit_exec_pkg::ST_INT_RD;
						end else begin
							state_r <= bit_exec_pkg::ST_EXT_REQ;
						end
					end
				end
				bit_exec_pkg::ST_INT_RD: begin
					state_r <= bit_exec_pkg::ST_IDLE;
					busy_out <= 1'b0;
				end
				bit_exec_pkg::ST_EXT_REQ: begin
					if (ack_lvl_r) begin
						state_r <= bit_exec_pkg::ST_EXT_REL;
					end
				end
				bit_exec_pkg::ST_EXT_REL: begin
					if (!ack_lvl_r) begin
						state_r <= bit_exec_pkg::ST_IDLE;
						busy_out <= 1'b0;
					end
				end
				default: state_r <= bit_exec_pkg::ST_IDLE;
			endcase
		end
	end

	// External bus drive; request held until acknowledged
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mem_addr_out <= 16'h0000;
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
			mem_wdata_out <= 8'h00;
			data_space_select_out <= 1'b0;
		end else if (state_r == bit_exec_pkg::ST_IDLE && mem_go &&
			!(cmd_op < bit_exec_pkg::OP_EXT_DATA_LOAD && pair_addr < 16'(PROG_BYTES))) begin
			mem_addr_out <= pair_addr;
			mem_req_out <= 1'b1;
			mem_we_out <= cmd_store_in && cmd_op >= bit_exec_pkg::OP_EXT_DATA_LOAD;
			// Incrementing store sends the byte that the pointer names
			mem_wdata_out <= cmd_op == bit_exec_pkg::OP_EXT_DATA_LOAD_INCR ?
				regs_r[regs_r[cmd_dst_in]] : regs_r[cmd_dst_in];
			// Data space marked only while select is enabled
			data_space_select_out <= ctrl_r[`CTRL_DSS_BIT] && cmd_op >= bit_exec_pkg::OP_EXT_DATA_LOAD;
		end else if (xfer_done && state_r == bit_exec_pkg::ST_EXT_REQ) begin
			mem_req_out <= 1'b0;
		end
	end

	// Internal program memory read
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pdata_r <= 8'h00;
		end else begin
			pdata_r <= prog_r[pair_addr[10:0]];
		end
	end

	//////////////////////////////////////////////////////////////////
	// Register file: bit op results, loads, pointer increments, software
	always_ff @(posedge core_clk_in) begin
		if (sw_wr_in && sw_addr_in == `OFS_REG_DATA) begin
			regs_r[reg_idx_r] <= sw_wdata_in;
		end
		if (bi.write_back) begin
			regs_r[cmd_dst_in] <= bi.result;
		end
		if (imm_go) begin
			regs_r[cmd_dst_in] <= cmd_src_in;
		end
		if (xfer_done) begin
			if (!store_r) begin
				// Direct target, or register named by the pointer
				regs_r[incr_r ? regs_r[tgt_r] : tgt_r] <= xfer_data;
			end
			if (incr_r) begin
				regs_r[tgt_r] <= regs_r[tgt_r] + 8'h01;
				{regs_r[pair_r], regs_r[pair_r | 8'h01]} <= maddr_r + 16'h0001;
			end
		end
	end

	// Internal program store, filled by software
	always_ff @(posedge core_clk_in) begin
		if (sw_wr_in && sw_addr_in == `OFS_PROG_DATA && prog_idx_r < 16'(PROG_BYTES)) begin
			prog_r[prog_idx_r[10:0]] <= sw_wdata_in;
		end
	end

	// Condition codes
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flags_r <= `FLAGS_RESET;
		end else if (bit_go) begin
			flags_r <= bi.flags_out;
		end else if (sw_wr_in && sw_addr_in == `OFS_FLAGS) begin
			flags_r <= sw_wdata_in;
		end
	end

	// Instruction length and refusal status
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			len_r <= 2'h0;
			err_r <= 1'b0;
		end else begin
			if (imm_go) begin
				len_r <= cmd_short_in ? `LEN_LOAD_IMM_SHORT : `LEN_LOAD_IMM_FULL;
			end
			// Refusal wins over a software clear
			if (accept && cmd_op >= bit_exec_pkg::OP_MASK_ZERO_TEST &&
				cmd_op <= bit_exec_pkg::OP_INVERT_ALL && wr_only) begin
				err_r <= 1'b1;
			end else if (sw_wr_in && sw_addr_in == `OFS_STATUS && sw_wdata_in[`STAT_ERR_BIT]) begin
				err_r <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// Software registers
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_r <= `CTRL_RESET;
			reg_idx_r <= 8'h00;
			prog_idx_r <= 16'h0000;
		end else if (sw_wr_in) begin
			case (sw_addr_in)
				`OFS_CTRL: ctrl_r <= {7'h00, sw_wdata_in[`CTRL_DSS_BIT]};
				`OFS_REG_IDX: reg_idx_r <= sw_wdata_in;
				`OFS_PROG_IDX: prog_idx_r <= {prog_idx_r[7:0], sw_wdata_in};
				`OFS_PROG_DATA: prog_idx_r <= prog_idx_r + 16'h0001;
				default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_comb begin
		status_r = 8'h00;
		status_r[`STAT_BUSY_BIT] = busy_out;
		status_r[`STAT_ERR_BIT] = err_r;
		status_r[`STAT_LEN_LSB +: 2] = len_r;
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sw_rdata_out <= 8'h00;
			flags_out <= `FLAGS_RESET;
		end else begin
			flags_out <= bit_go ? bi.flags_out : flags_r;
			if (sw_rd_in) begin
				case (sw_addr_in)
					`OFS_CTRL: sw_rdata_out <= ctrl_r;
					`OFS_STATUS: sw_rdata_out <= status_r;
					`OFS_FLAGS: sw_rdata_out <= flags_r;
					`OFS_REG_IDX: sw_rdata_out <= reg_idx_r;
					`OFS_REG_DATA: sw_rdata_out <= regs_r[reg_idx_r];
					`OFS_PROG_IDX: sw_rdata_out <= prog_idx_r[7:0];
					default: sw_rdata_out <= 8'h00;
				endcase
			end else begin
				sw_rdata_out <= 8'h00;
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// Checks
	a_test_keeps_dst: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		bit_go && cmd_op <= bit_exec_pkg::OP_MASK_ONE_TEST && state_r == bit_exec_pkg::ST_IDLE && !sw_wr_in
		|=> regs_r[$past(cmd_dst_in)] == $past(regs_r[cmd_dst_in])) else $error("test altered operand");
	a_zero_test_z: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		bit_go && cmd_op == bit_exec_pkg::OP_MASK_ZERO_TEST
		|=> flags_r[`FLAG_Z] == (($past(regs_r[cmd_dst_in]) & $past(cmd_src_in)) == 8'h00))
		else $error("zero test Z wrong");
	a_one_test_z: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		bit_go && cmd_op == bit_exec_pkg::OP_MASK_ONE_TEST
		|=> flags_r[`FLAG_Z] == (($past(regs_r[cmd_dst_in]) & $past(cmd_src_in)) == $past(cmd_src_in)))
		else $error("one test Z wrong");
	a_test_sign_bit: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		bit_go && cmd_op == bit_exec_pkg::OP_MASK_ZERO_TEST
		|=> flags_r[`FLAG_S] == ($past(regs_r[cmd_dst_in][7]) & $past(cmd_src_in[7])))
		else $error("test sign wrong");
	a_test_v_clear: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		bit_go |=> !flags_r[`FLAG_V] && flags_r[`FLAG_C] == $past(flags_r[`FLAG_C]))
		else $error("V or C mishandled");
	a_invert_all: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		bit_go && cmd_op == bit_exec_pkg::OP_INVERT_ALL && !imm_go
		|=> regs_r[$past(cmd_dst_in)] == ~$past(regs_r[cmd_dst_in])) else $error("invert wrong");
	a_write_only_refused: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		accept && wr_only && cmd_op == bit_exec_pkg::OP_OR |=> err_r && flags_r == $past(flags_r))
		else $error("write-only register modified");
	a_internal_no_bus: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		state_r == bit_exec_pkg::ST_IDLE && mem_go && cmd_op == bit_exec_pkg::OP_PROGRAM_MEM_LOAD &&
		pair_addr < 16'(PROG_BYTES) |=> !mem_req_out ##1 !busy_out) else $error("internal fetch used bus");
	a_imm_length: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		imm_go |=> len_r == ($past(cmd_short_in) ? 2'h2 : 2'h3)) else $error("immediate length wrong");
	a_dss_marks_data: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		mem_req_out && data_space_select_out |-> ctrl_r[`CTRL_DSS_BIT] && is_ext_r)
		else $error("data space select misused");
endmodule

// ===== testbench/ext_mem_model.sv
/*
 * Behavioural external memory: program and data spaces, each answering a
 * held request with an acknowledge level after a chosen delay.
 * Assumes the block holds its request until the acknowledge is seen.
 */
`timescale 1ns/100ps
module ext_mem_model (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Memory bus from the block
	input wire logic [15:0] mem_addr_in,
	input wire logic mem_req_in,
	input wire logic mem_we_in,
	input wire logic [7:0] mem_wdata_in,
	input wire logic data_space_select_in,
	input wire logic [3:0] delay_in,
	// Answer to the block
	output logic mem_ack_out,
	output logic [7:0] mem_rdata_out
);
	logic [7:0] mem [0:511];
	logic [3:0] wait_r;
	logic [8:0] idx;
	// Program and data spaces kept apart by the select line
	assign idx = {data_space_select_in, mem_addr_in[7:0]};
	// Fixed pattern so every byte is predictable
	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = i[7:0] ^ (i[8] ? 8'h5A : 8'hC3);
		end
	end
	// Acknowledge after the delay, held until the request drops
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mem_ack_out <= 1'b0;
			mem_rdata_out <= 8'hFF;
			wait_r <= 4'h0;
		end else if (mem_req_in && !mem_ack_out) begin
			if (wait_r >= delay_in) begin
				mem_ack_out <= 1'b1;
				if (mem_we_in) begin
					mem[idx] <= mem_wdata_in;
				end else begin
					mem_rdata_out <= mem[idx];
				end
			end else begin
				wait_r <= wait_r + 4'h1;
			end
		end else if (!mem_req_in && mem_ack_out) begin
			mem_ack_out <= 1'b0;
			mem_rdata_out <= ~mem_rdata_out; // Released bus shows no stale byte
			wait_r <= 4'h0;
		end
	end
endmodule

// ===== testbench/testbench.sv
/*
 * Self-checking bench for the execution block: register port and command
 * tasks, and sequences of calls with worked-out expectations.
 * Assumes the external memory model on the far side of the block.
 */
`timescale 1ns/100ps
`include "bit_exec_regs.svh"
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin miscompares++; \
	$display("[FAIL] %0t got %h expected %h", $time, act, exp); end end
module testbench;
	logic core_clk_in, rst_b_in, sw_wr_in, sw_rd_in, cmd_valid_in, cmd_store_in, cmd_short_in, mem_ack_in;
	logic [7:0] sw_addr_in, sw_wdata_in, sw_rdata_out, cmd_dst_in, cmd_src_in, cmd_pair_in, flags_out;
	logic [7:0] mem_wdata_out, mem_rdata_in, rv;
	logic [3:0] cmd_op_in, delay;
	logic busy_out, mem_req_out, mem_we_out, data_space_select_out, req_q, last_dss;
	logic [15:0] mem_addr_out, last_addr;
	int miscompares, cmp_count, req_cnt;
	localparam logic [7:0] TDST [6] = '{8'h8C, 8'h7C, 8'h8C, 8'hFC, 8'h18, 8'h40};
	localparam logic [7:0] TSRC [6] = '{8'h70, 8'h70, 8'hF0, 8'hF0, 8'hA1, 8'hA1};
	localparam logic [7:0] WO [7] = '{`ADDR_PRESCALER0, `ADDR_PRESCALER1, `ADDR_PORT01_MODE,
		`ADDR_PORT2_MODE, `ADDR_PORT3_MODE, `ADDR_IRQ_PRIORITY, 8'hF4};
	localparam logic [7:0] MRES [4] = '{8'h03, 8'hCF, 8'hCC, 8'h3C};

	bit_exec i_bit_exec (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .sw_addr_in(sw_addr_in),
		.sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
		.cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_dst_in(cmd_dst_in), .cmd_src_in(cmd_src_in),
		.cmd_pair_in(cmd_pair_in), .cmd_store_in(cmd_store_in), .cmd_short_in(cmd_short_in),
		.busy_out(busy_out), .flags_out(flags_out), .mem_addr_out(mem_addr_out), .mem_req_out(mem_req_out),
		.mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out), .data_space_select_out(data_space_select_out),
		.mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));
	ext_mem_model i_ext_mem_model (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .mem_addr_in(mem_addr_out),
		.mem_req_in(mem_req_out), .mem_we_in(mem_we_out), .mem_wdata_in(mem_wdata_out),
		.data_space_select_in(data_space_select_out), .delay_in(delay), .mem_ack_out(mem_ack_in),
		.mem_rdata_out(mem_rdata_in));

	//////////////////////////////////////////////////////////////////////
	// Clock, 40 ns period
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	// Counts external requests and keeps the last address
	always @(posedge core_clk_in) begin
		req_q <= mem_req_out;
		if (mem_req_out && !req_q) begin
			req_cnt <= req_cnt + 1;
			last_addr <= mem_addr_out;
			last_dss <= data_space_select_out;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic print_verdict();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	function automatic logic [7:0] pat(input logic s, input logic [7:0] a);
		return a ^ (s ? 8'h5A : 8'hC3);
	endfunction
	// Register port accesses
	task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		sw_wr_in <= 1'b1;
		sw_addr_in <= a;
		sw_wdata_in <= d;
		@(posedge core_clk_in);
		sw_wr_in <= 1'b0;
	endtask
	task automatic sw_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		sw_rd_in <= 1'b1;
		sw_addr_in <= a;
		@(posedge core_clk_in);
		sw_rd_in <= 1'b0;
		#1 d = sw_rdata_out;
	endtask
	task automatic reg_wr(input logic [7:0] r, input logic [7:0] d);
		sw_wr(`OFS_REG_IDX, r);
		sw_wr(`OFS_REG_DATA, d);
	endtask
	task automatic chk_reg(input logic [7:0] r, input logic [7:0] e);
		logic [7:0] d;
		sw_wr(`OFS_REG_IDX, r);
		sw_rd(`OFS_REG_DATA, d);
		`CHK(d, e)
	endtask
	// One command, then a bounded wait for the block to go idle
	task automatic cmd(input bit_exec_pkg::op_t op, input logic [7:0] dst, input logic [7:0] src,
		input logic [7:0] pair, input logic st);
		int n;
		@(posedge core_clk_in);
		cmd_valid_in <= 1'b1;
		cmd_op_in <= op;
		cmd_dst_in <= dst;
		cmd_src_in <= src;
		cmd_pair_in <= pair;
		cmd_store_in <= st;
		cmd_short_in <= st;
		@(posedge core_clk_in);
		cmd_valid_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		#1;
		for (n = 0; n < 300 && busy_out !== 1'b0; n++) begin
			@(posedge core_clk_in);
			#1;
		end
		if (n == 300) begin
			miscompares++;
			$display("[FAIL] %0t busy stuck", $time);
			print_verdict();
		end
	endtask

	//////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] d, m, e, ex;
		{rst_b_in, sw_wr_in, sw_rd_in, cmd_valid_in, cmd_store_in, cmd_short_in, req_q} = 7'h00;
		{sw_addr_in, sw_wdata_in, cmd_dst_in, cmd_src_in, cmd_pair_in} = 40'h0;
		cmd_op_in = 4'h0;
		delay = 4'h0;
		{miscompares, cmp_count, req_cnt} = 0;
		repeat (2) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		// Reset values and an unmapped read
		sw_rd(`OFS_CTRL, rv);
		`CHK(rv, `CTRL_RESET)
		sw_rd(8'h20, rv);
		`CHK(rv, 8'h00)
		`CHK(flags_out, `FLAGS_RESET)
		// Both masked tests over the table operands
		for (int t = 0; t < 12; t++) begin
			d = TDST[t % 6];
			m = TSRC[t % 6];
			e = (t < 6) ? (d & m) : (~d & m);
			ex = 8'h9F;
			ex[`FLAG_Z] = (e == 8'h00);
			ex[`FLAG_S] = e[7];
			ex[`FLAG_V] = 1'b0;
			reg_wr(8'h20, d);
			sw_wr(`OFS_FLAGS, 8'h9F);
			cmd((t < 6) ? bit_exec_pkg::OP_MASK_ZERO_TEST : bit_exec_pkg::OP_MASK_ONE_TEST, 8'h20, m, 8'h00, 1'b0);
			`CHK(flags_out, ex)
			chk_reg(8'h20, d);
		end
		// Modify ops: AND, OR, XOR, invert-all with an ignored mask
		for (int k = 0; k < 4; k++) begin
			reg_wr(8'h21, 8'hC3);
			cmd(bit_exec_pkg::op_t'(k + 3), 8'h21, 8'h0F, 8'h00, 1'b0);
			chk_reg(8'h21, MRES[k]);
		end
		// Write-only targets refused, a plain control register reached
		reg_wr(8'hF4, 8'h00);
		for (int k = 0; k < 7; k++) begin
			sw_wr(`OFS_FLAGS, 8'h9F);
			cmd(bit_exec_pkg::OP_OR, WO[k], 8'h06, 8'h00, 1'b0);
			`CHK(flags_out, (k < 6) ? 8'h9F : 8'h8F)
			sw_rd(`OFS_STATUS, rv);
			`CHK(rv[`STAT_ERR_BIT], k < 6)
			sw_wr(`OFS_STATUS, 8'h02);
		end
		sw_rd(`OFS_STATUS, rv);
		`CHK(rv[`STAT_ERR_BIT], 1'b0)
		// Program table straddling the internal store's upper end
		sw_wr(`OFS_PROG_IDX, 8'h07);
		sw_wr(`OFS_PROG_IDX, 8'hFE);
		sw_wr(`OFS_PROG_DATA, 8'hA7);
		sw_wr(`OFS_PROG_DATA, 8'h3B);
		reg_wr(8'h30, 8'h07);
		reg_wr(8'h31, 8'hFF);
		cmd(bit_exec_pkg::OP_PROGRAM_MEM_LOAD, 8'h40, 8'h00, 8'h30, 1'b0);
		chk_reg(8'h40, 8'h3B);
		`CHK(req_cnt, 0)
		reg_wr(8'h31, 8'hFE);
		reg_wr(8'h32, 8'h50);
		for (int k = 0; k < 3; k++) begin
			cmd(bit_exec_pkg::OP_PROGRAM_MEM_LOAD_INCR, 8'h32, 8'h00, 8'h30, 1'b0);
		end
		chk_reg(8'h50, 8'hA7);
		chk_reg(8'h51, 8'h3B);
		chk_reg(8'h52, pat(1'b0, 8'h00));
		`CHK(req_cnt, 1)
		`CHK({last_dss, last_addr}, 17'h00800)
		chk_reg(8'h32, 8'h53);
		chk_reg(8'h30, 8'h08);
		chk_reg(8'h31, 8'h01);
		// Data space enabled; no port mode write precedes the external loads
		sw_wr(`OFS_CTRL, 8'h01);
		delay <= 4'h5;
		reg_wr(8'h34, 8'h12);
		reg_wr(8'h35, 8'hFF);
		reg_wr(8'h36, 8'h70);
		cmd(bit_exec_pkg::OP_EXT_DATA_LOAD, 8'h60, 8'h00, 8'h34, 1'b0);
		chk_reg(8'h60, pat(1'b1, 8'hFF));
		`CHK({last_dss, last_addr}, 17'h112FF)
		delay <= 4'h0;
		repeat (2) cmd(bit_exec_pkg::OP_EXT_DATA_LOAD_INCR, 8'h36, 8'h00, 8'h34, 1'b0);
		chk_reg(8'h70, pat(1'b1, 8'hFF));
		chk_reg(8'h71, pat(1'b1, 8'h00));
		chk_reg(8'h34, 8'h13);
		chk_reg(8'h35, 8'h01);
		chk_reg(8'h36, 8'h72);
		reg_wr(8'h72, 8'hE4);
		cmd(bit_exec_pkg::OP_EXT_DATA_LOAD_INCR, 8'h36, 8'h00, 8'h34, 1'b1);
		`CHK(i_ext_mem_model.mem[9'h101], 8'hE4)
		chk_reg(8'h36, 8'h73);
		chk_reg(8'h35, 8'h02);
		// Load immediate in full and short forms
		for (int k = 0; k < 2; k++) begin
			cmd(bit_exec_pkg::OP_LOAD_IMM, 8'h80, k ? 8'h5D : 8'h5C, 8'h00, k[0]);
			chk_reg(8'h80, k ? 8'h5D : 8'h5C);
			sw_rd(`OFS_STATUS, rv);
			`CHK(rv[`STAT_LEN_LSB +: 2], k ? `LEN_LOAD_IMM_SHORT : `LEN_LOAD_IMM_FULL)
		end
		print_verdict();
	end
endmodule
